// file: dsw_regs.svh
`ifndef DSW_REGS_SVH
`define DSW_REGS_SVH

// Status word bit positions
`define DSW_BIT_CTRL_READY    0
`define DSW_BIT_DRIVE_READY   1
`define DSW_BIT_ENABLE        2
`define DSW_BIT_TRIP          3
`define DSW_BIT_ERROR         4
`define DSW_BIT_RESERVED      5
`define DSW_BIT_TRIPLOCK      6
`define DSW_BIT_WARNING       7
`define DSW_BIT_AT_REF        8
`define DSW_BIT_BUS_CTRL      9
`define DSW_BIT_FREQ_OK       10
`define DSW_BIT_RUNNING       11
`define DSW_BIT_AUTO_STOP     12
`define DSW_BIT_VOLT_EXC      13
`define DSW_BIT_TORQUE_EXC    14
`define DSW_BIT_TIMER_EXC     15

// Control word bit positions
`define DSW_CW_RESET          7
`define DSW_CW_DATA_VALID     10
`define DSW_CW_REVERSE        15

// Reset values and scaling
`define DSW_STATUS_RESET      16'h0000
`define DSW_REF_FULL_SCALE    16'h4000
`define DSW_THERMAL_FULL      16'h4000

`endif

// file: dsw_pkg.sv
package dsw_pkg;

   typedef enum logic [1:0] {
      DSW_REV_DIGITAL,
      DSW_REV_BUS,
      DSW_REV_LOGIC_OR,
      DSW_REV_LOGIC_AND
   } dsw_rev_sel_type;

   typedef enum {
      DSW_ST_RUN,
      DSW_ST_TRIP,
      DSW_ST_TRIPLOCK
   } dsw_fault_state_type;

endpackage

// file: dsw_fault_if.sv
`timescale 1ns/1ps

interface dsw_fault_if;
   logic alarm;
   logic alarm_lock;
   logic reset_req;
   logic power_cycle;
   logic tripped;
   logic locked;
   modport ctrl (output alarm, output alarm_lock, output reset_req, output power_cycle,
                 input tripped, input locked);
   modport fsm  (input alarm, input alarm_lock, input reset_req, input power_cycle,
                 output tripped, output locked);
endinterface

// file: dsw_fault_latch.sv
`timescale 1ns/1ps

// ****************************************
// Trip and trip-lock holder
// ****************************************
module dsw_fault_latch (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   dsw_fault_if.fsm  flt
);

   dsw_pkg::dsw_fault_state_type state_r;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_r <= dsw_pkg::DSW_ST_RUN;
      end else begin
         case (state_r)
            dsw_pkg::DSW_ST_RUN: begin
               if (flt.alarm_lock) begin
                  state_r <= dsw_pkg::DSW_ST_TRIPLOCK;
               end else if (flt.alarm) begin
                  state_r <= dsw_pkg::DSW_ST_TRIP;
               end
            end
            dsw_pkg::DSW_ST_TRIP: begin
               if (flt.alarm_lock) begin
                  state_r <= dsw_pkg::DSW_ST_TRIPLOCK;
               end else if (flt.reset_req && !flt.alarm) begin
                  state_r <= dsw_pkg::DSW_ST_RUN;
               end
            end
            dsw_pkg::DSW_ST_TRIPLOCK: begin
               if (flt.power_cycle && !flt.alarm_lock && !flt.alarm) begin
                  state_r <= dsw_pkg::DSW_ST_TRIP;
               end
            end
            default: state_r <= dsw_pkg::DSW_ST_RUN;
         endcase
      end
   end

   assign flt.tripped = (state_r != dsw_pkg::DSW_ST_RUN);
   assign flt.locked  = (state_r == dsw_pkg::DSW_ST_TRIPLOCK);

endmodule

// file: dsw_encoder.sv
`timescale 1ns/1ps
`include "dsw_regs.svh"

module dsw_encoder (
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   // Bus control word
   input  wire logic [15:0]        ctrl_word,
   input  wire logic               ctrl_word_strobe,
   input  wire logic [1:0]         rev_source_sel,
   input  wire logic               rev_digital_in,
   // Condition inputs from pins
   input  wire logic               alarm_in,
   input  wire logic               alarm_lock_in,
   input  wire logic               power_cycle_in,
   input  wire logic               panel_reset_in,
   input  wire logic               dig_reset_in,
   input  wire logic               auto_reset_in,
   input  wire logic               coast_active_in,
   input  wire logic               error_no_trip_in,
   input  wire logic [7:0]         warning_in,
   input  wire logic               local_stop_in,
   input  wire logic               local_site_in,
   input  wire logic               start_in,
   input  wire logic               over_temp_in,
   input  wire logic               dc_low_in,
   input  wire logic               dc_high_in,
   input  wire logic               link_lost_in,
   input  wire logic               comm_fault_in,
   // Measured quantities, same clock
   input  wire logic signed [15:0] speed_ref,
   input  wire logic signed [15:0] out_freq,
   input  wire logic signed [15:0] freq_low_limit,
   input  wire logic signed [15:0] freq_high_limit,
   input  wire logic [15:0]        motor_current,
   input  wire logic [15:0]        current_limit,
   input  wire logic [15:0]        motor_thermal,
   input  wire logic [15:0]        drive_thermal,
   // Results
   output logic [15:0]             drive_status_word,
   output logic signed [15:0]      actual_output_frequency_word,
   output logic                    reverse_r,
   output logic                    bus_reset_pulse_r
);

   localparam int NSYNC = 22;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] sync1_r;
   logic [NSYNC-1:0] sync2_r;

   assign pin_raw = {alarm_in, alarm_lock_in, power_cycle_in, panel_reset_in,
                     dig_reset_in, auto_reset_in, coast_active_in, error_no_trip_in,
                     warning_in, local_stop_in, local_site_in, start_in,
                     over_temp_in, dc_low_in, dc_high_in};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               sync1_r[gi] <= 1'b0;
               sync2_r[gi] <= 1'b0;
            end else begin
               sync1_r[gi] <= pin_raw[gi];
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate

   logic       s_alarm, s_lock, s_pcyc, s_pnl_rst, s_dig_rst, s_auto_rst, s_coast, s_err;
   logic [7:0] s_warn;
   logic       s_loc_stop, s_loc_site, s_start, s_otemp, s_dc_low, s_dc_high;

   assign {s_alarm, s_lock, s_pcyc, s_pnl_rst, s_dig_rst, s_auto_rst, s_coast, s_err,
           s_warn, s_loc_stop, s_loc_site, s_start, s_otemp, s_dc_low, s_dc_high} = sync2_r;

   // Link loss flags synchronised separately
   logic [1:0] lnk1_r;
   logic [1:0] lnk2_r;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         lnk1_r <= 2'h0;
         lnk2_r <= 2'h0;
      end else begin
         lnk1_r <= {link_lost_in, comm_fault_in};
         lnk2_r <= lnk1_r;
      end
   end

   // ****************************************
   // Control word capture
   // ****************************************
   logic [15:0] cw_r;
   logic        cw_reset_prev_r;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cw_r <= 16'h0000;
      end else if (ctrl_word_strobe && ctrl_word[`DSW_CW_DATA_VALID]) begin
         cw_r <= ctrl_word;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cw_reset_prev_r   <= 1'b0;
         bus_reset_pulse_r <= 1'b0;
      end else begin
         cw_reset_prev_r   <= cw_r[`DSW_CW_RESET];
         bus_reset_pulse_r <= cw_r[`DSW_CW_RESET] && !cw_reset_prev_r;
      end
   end

   // ****************************************
   // Reversing
   // ****************************************
   logic bus_rev;
   assign bus_rev = cw_r[`DSW_CW_REVERSE];

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reverse_r <= 1'b0;
      end else begin
         case (dsw_pkg::dsw_rev_sel_type'(rev_source_sel))
            dsw_pkg::DSW_REV_BUS:       reverse_r <= bus_rev;
            dsw_pkg::DSW_REV_LOGIC_OR:  reverse_r <= bus_rev || rev_digital_in;
            dsw_pkg::DSW_REV_LOGIC_AND: reverse_r <= bus_rev && rev_digital_in;
            default:                    reverse_r <= rev_digital_in;
         endcase
      end
   end

   // ****************************************
   // Trip handling
   // ****************************************
   dsw_fault_if flt ();

   assign flt.alarm       = s_alarm;
   assign flt.alarm_lock  = s_lock;
   assign flt.power_cycle = s_pcyc;
   assign flt.reset_req   = s_pnl_rst || s_dig_rst || s_auto_rst || bus_reset_pulse_r;

   dsw_fault_latch u_fault (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .flt     (flt)
   );

   // ****************************************
   // Status word snapshot
   // ****************************************
   logic [15:0] stw_nxt;
   logic        therm_exc;

   assign therm_exc = (motor_thermal > `DSW_THERMAL_FULL) || (drive_thermal > `DSW_THERMAL_FULL);

   always_comb begin
      stw_nxt                        = `DSW_STATUS_RESET;
      stw_nxt[`DSW_BIT_CTRL_READY]   = !flt.tripped;
      stw_nxt[`DSW_BIT_DRIVE_READY]  = !flt.tripped && s_coast;
      stw_nxt[`DSW_BIT_ENABLE]       = !flt.tripped && !s_coast && !s_otemp;
      stw_nxt[`DSW_BIT_TRIP]         = flt.tripped && !flt.locked;
      stw_nxt[`DSW_BIT_ERROR]        = s_err;
      stw_nxt[`DSW_BIT_RESERVED]     = 1'b0;
      stw_nxt[`DSW_BIT_TRIPLOCK]     = flt.locked;
      stw_nxt[`DSW_BIT_WARNING]      = |s_warn;
      stw_nxt[`DSW_BIT_AT_REF]       = (out_freq == speed_ref);
      stw_nxt[`DSW_BIT_BUS_CTRL]     = !(s_loc_stop || s_loc_site);
      stw_nxt[`DSW_BIT_FREQ_OK]      = (out_freq > freq_low_limit)
                                       && (out_freq < freq_high_limit);
      stw_nxt[`DSW_BIT_RUNNING]      = s_start || (out_freq != 16'sh0000);
      stw_nxt[`DSW_BIT_AUTO_STOP]    = s_otemp && !flt.tripped;
      stw_nxt[`DSW_BIT_VOLT_EXC]     = s_dc_low || s_dc_high;
      stw_nxt[`DSW_BIT_TORQUE_EXC]   = motor_current > current_limit;
      stw_nxt[`DSW_BIT_TIMER_EXC]    = therm_exc;
      if (lnk2_r != 2'h0) begin
         stw_nxt = 16'h0000;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         drive_status_word <= `DSW_STATUS_RESET;
      end else begin
         drive_status_word <= stw_nxt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         actual_output_frequency_word <= 16'sh0000;
      end else begin
         actual_output_frequency_word <= out_freq;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_link_clear;
      @(posedge sys_clk) disable iff (!rst_n) (lnk2_r != 2'h0) |=> (drive_status_word == 16'h0000);
   endproperty
   a_link_clear: assert property (p_link_clear) else $error("status not cleared");

   property p_reserved;
      @(posedge sys_clk) disable iff (!rst_n) !drive_status_word[`DSW_BIT_RESERVED];
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_snapshot;
      @(posedge sys_clk) disable iff (!rst_n) rst_n |=> (drive_status_word == $past(stw_nxt));
   endproperty
   a_snapshot: assert property (p_snapshot) else $error("status not snapshotted");

   property p_ready_trip;
      @(posedge sys_clk) disable iff (!rst_n)
         (drive_status_word[`DSW_BIT_TRIP] || drive_status_word[`DSW_BIT_TRIPLOCK])
         |-> !drive_status_word[`DSW_BIT_CTRL_READY];
   endproperty
   a_ready_trip: assert property (p_ready_trip) else $error("ready while tripped");

   property p_reset_edge;
      @(posedge sys_clk) disable iff (!rst_n) bus_reset_pulse_r |=> !bus_reset_pulse_r;
   endproperty
   a_reset_edge: assert property (p_reset_edge) else $error("reset not an edge");

   property p_ignore_invalid;
      @(posedge sys_clk) disable iff (!rst_n)
         (ctrl_word_strobe && !ctrl_word[`DSW_CW_DATA_VALID]) |=> $stable(cw_r);
   endproperty
   a_ignore_invalid: assert property (p_ignore_invalid) else $error("invalid word used");

   property p_rev_digital;
      @(posedge sys_clk) disable iff (!rst_n)
         (rev_source_sel == 2'h0) |=> (reverse_r == $past(rev_digital_in));
   endproperty
   a_rev_digital: assert property (p_rev_digital) else $error("bus reversed in digital");

   property p_warn_follow;
      @(posedge sys_clk) disable iff (!rst_n)
         (lnk2_r == 2'h0) |=> (drive_status_word[`DSW_BIT_WARNING] == $past(|s_warn));
   endproperty
   a_warn_follow: assert property (p_warn_follow) else $error("warning not tracking");

   property p_freq_scale;
      @(posedge sys_clk) disable iff (!rst_n) rst_n |=> (actual_output_frequency_word == $past(out_freq));
   endproperty
   a_freq_scale: assert property (p_freq_scale) else $error("frequency word wrong");

   property p_reset_rise;
      @(posedge sys_clk) disable iff (!rst_n)
         bus_reset_pulse_r |-> (cw_reset_prev_r && !$past(cw_reset_prev_r));
   endproperty
   a_reset_rise: assert property (p_reset_rise) else $error("reset pulse without rise");

   property p_trip_hold;
      @(posedge sys_clk) disable iff (!rst_n)
         (flt.tripped && !flt.reset_req) |=> flt.tripped;
   endproperty
   a_trip_hold: assert property (p_trip_hold) else $error("trip dropped without reset");

   property p_alarm_trip;
      @(posedge sys_clk) disable iff (!rst_n)
         flt.alarm |=> flt.tripped;
   endproperty
   a_alarm_trip: assert property (p_alarm_trip) else $error("alarm did not trip");

   property p_rev_bus;
      @(posedge sys_clk) disable iff (!rst_n)
         (rev_source_sel == 2'h1) |=> (reverse_r == $past(bus_rev));
   endproperty
   a_rev_bus: assert property (p_rev_bus) else $error("bus reverse not followed");

endmodule

// file: dsw_bus_master.sv
`timescale 1ns/1ps

// ****************************************
// Bus master: control words and reference
// ****************************************
module dsw_bus_master (
   input  wire logic          sys_clk,
   output logic        [15:0] ctrl_word,
   output logic               ctrl_word_strobe,
   output logic signed [15:0] speed_ref
);
   initial begin
      ctrl_word        = 16'h0000;
      ctrl_word_strobe = 1'b0;
      speed_ref        = 16'sh0000;
   end

   // One-cycle word, then the data lines show the inverse
   task automatic send(input logic [15:0] w);
      @(posedge sys_clk);
      ctrl_word        <= w;
      ctrl_word_strobe <= 1'b1;
      @(posedge sys_clk);
      ctrl_word_strobe <= 1'b0;
      ctrl_word        <= ~w;
   endtask

   // Signed relative value, 4000 hex is full scale
   task automatic set_ref(input logic signed [15:0] r);
      @(posedge sys_clk);
      speed_ref <= r;
   endtask
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
`include "dsw_regs.svh"

module tb_top;
   logic sys_clk = 1'b0, rst_n = 1'b0, rev_digital_in = 1'b0;
   logic [1:0] rev_source_sel = 2'h0;
   logic alarm_in = 1'b0, alarm_lock_in = 1'b0, power_cycle_in = 1'b0, panel_reset_in = 1'b0;
   logic dig_reset_in = 1'b0, auto_reset_in = 1'b0, coast_active_in = 1'b0, start_in = 1'b0;
   logic error_no_trip_in = 1'b0, local_stop_in = 1'b0, local_site_in = 1'b0, over_temp_in = 1'b0;
   logic dc_low_in = 1'b0, dc_high_in = 1'b0, link_lost_in = 1'b0, comm_fault_in = 1'b0;
   logic [7:0] warning_in = 8'h00;
   logic signed [15:0] out_freq = 16'sh0000, freq_low_limit = 16'sh0000;
   logic signed [15:0] freq_high_limit = 16'sh0000, speed_ref, actual_output_frequency_word;
   logic [15:0] motor_current = 16'h0000, current_limit = 16'h0000;
   logic [15:0] motor_thermal = 16'h0000, drive_thermal = 16'h0000;
   logic [15:0] ctrl_word, drive_status_word, lfsr = 16'h035D;
   logic ctrl_word_strobe, reverse_r, bus_reset_pulse_r, m_trip = 1'b0, m_lock = 1'b0;
   int n_fail = 0, check_count = 0, cyc = 0, n_pulse = 0, m_pulse = 0;

   dsw_encoder dut (.sys_clk, .rst_n, .ctrl_word, .ctrl_word_strobe, .rev_source_sel,
      .rev_digital_in, .alarm_in, .alarm_lock_in, .power_cycle_in, .panel_reset_in,
      .dig_reset_in, .auto_reset_in, .coast_active_in, .error_no_trip_in, .warning_in,
      .local_stop_in, .local_site_in, .start_in, .over_temp_in, .dc_low_in, .dc_high_in,
      .link_lost_in, .comm_fault_in, .speed_ref, .out_freq, .freq_low_limit, .freq_high_limit,
      .motor_current, .current_limit, .motor_thermal, .drive_thermal, .drive_status_word,
      .actual_output_frequency_word, .reverse_r, .bus_reset_pulse_r);

   dsw_bus_master u_master (.sys_clk, .ctrl_word, .ctrl_word_strobe, .speed_ref);

   initial begin
      forever #5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cyc++;
      if (bus_reset_pulse_r === 1'b1) n_pulse++;
      if (cyc == 5000) begin
         n_fail++;
         summarize();
      end
   end

   // ****************************************
   // Reference model and helpers
   // ****************************************
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction

   function automatic logic [15:0] exp_status();
      logic [15:0] s;
      logic        ok;
      s  = 16'h0000;
      ok = !(m_trip || m_lock);
      if (link_lost_in || comm_fault_in) return s;
      s[0]  = ok;
      s[1]  = ok && coast_active_in;
      s[2]  = ok && !coast_active_in && !over_temp_in;
      s[3]  = m_trip;
      s[4]  = error_no_trip_in;
      s[6]  = m_lock;
      s[7]  = |warning_in;
      s[8]  = out_freq == speed_ref;
      s[9]  = !(local_stop_in || local_site_in);
      s[10] = out_freq > freq_low_limit && out_freq < freq_high_limit;
      s[11] = start_in || out_freq != 0;
      s[12] = ok && over_temp_in;
      s[13] = dc_low_in || dc_high_in;
      s[14] = motor_current > current_limit;
      s[15] = motor_thermal > `DSW_THERMAL_FULL || drive_thermal > `DSW_THERMAL_FULL;
      return s;
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic settle();
      repeat (5) @(posedge sys_clk);
      #1;
   endtask

   task automatic pulse_rst(input logic [2:0] v);
      @(posedge sys_clk) begin
         panel_reset_in <= v[2];
         dig_reset_in   <= v[1];
         auto_reset_in  <= v[0];
      end
      repeat (2) @(posedge sys_clk);
      panel_reset_in <= 1'b0;
      dig_reset_in   <= 1'b0;
      auto_reset_in  <= 1'b0;
      settle();
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [15:0] r, f, a, b;
      logic        e;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      settle();
      check(drive_status_word, exp_status());
      $display("test reset done");
      for (int i = 0; i < 24; i++) begin
         r = rnd();
         f = (i % 8 == 4) ? 16'h0000 : rnd();
         a = rnd();
         b = rnd();
         u_master.set_ref((i % 4 == 0) ? f : a);
         coast_active_in  <= r[7] & r[15];
         error_no_trip_in <= r[6] & r[14];
         local_stop_in    <= r[5] & r[13];
         local_site_in    <= r[4] & r[12];
         start_in         <= r[3] & r[11];
         over_temp_in     <= r[2] & r[10];
         dc_low_in        <= r[1] & r[9];
         dc_high_in       <= r[0] & r[8];
         warning_in      <= (i % 3 == 0) ? 8'h00 : 8'h01 << r[2:0];
         out_freq        <= f;
         freq_low_limit  <= (i % 4 == 0) ? f : a;
         freq_high_limit <= (i % 4 == 2) ? f : b;
         motor_current   <= a;
         current_limit   <= (i % 4 == 0) ? a : b;
         motor_thermal   <= (i % 4 == 0) ? `DSW_THERMAL_FULL : f;
         drive_thermal   <= b;
         settle();
         check(drive_status_word, exp_status());
         check(actual_output_frequency_word, out_freq);
      end
      $display("test random done");
      for (int k = 1; k < 3; k++) begin
         @(posedge sys_clk) begin
            link_lost_in  <= k[1];
            comm_fault_in <= k[0];
         end
         settle();
         check(drive_status_word, 16'h0000);
      end
      @(posedge sys_clk) begin
         link_lost_in  <= 1'b0;
         comm_fault_in <= 1'b0;
      end
      $display("test link done");
      @(posedge sys_clk) alarm_in <= 1'b1;
      m_trip = 1'b1;
      u_master.send(16'h0480);
      m_pulse++;
      settle();
      check(drive_status_word, exp_status());
      @(posedge sys_clk) alarm_in <= 1'b0;
      settle();
      u_master.send(16'h0000);
      u_master.send(16'h0480);
      settle();
      check(drive_status_word, exp_status());
      u_master.send(16'h0400);
      u_master.send(16'h0480);
      m_pulse++;
      m_trip = 1'b0;
      settle();
      check(drive_status_word, exp_status());
      check(16'(n_pulse), 16'(m_pulse));
      for (int k = 0; k < 3; k++) begin
         @(posedge sys_clk) alarm_in <= 1'b1;
         m_trip = 1'b1;
         settle();
         @(posedge sys_clk) alarm_in <= 1'b0;
         settle();
         check(drive_status_word, exp_status());
         pulse_rst(3'b100 >> k);
         m_trip = 1'b0;
         check(drive_status_word, exp_status());
      end
      $display("test trip done");
      @(posedge sys_clk) alarm_lock_in <= 1'b1;
      m_lock = 1'b1;
      settle();
      @(posedge sys_clk) alarm_lock_in <= 1'b0;
      pulse_rst(3'b100);
      check(drive_status_word & 16'h0041, exp_status() & 16'h0041);
      @(posedge sys_clk) power_cycle_in <= 1'b1;
      settle();
      @(posedge sys_clk) power_cycle_in <= 1'b0;
      {m_lock, m_trip} = 2'b01;
      settle();
      check(drive_status_word, exp_status());
      pulse_rst(3'b010);
      m_trip = 1'b0;
      check(drive_status_word, exp_status());
      $display("test lock done");
      for (int k = 0; k < 16; k++) begin
         @(posedge sys_clk) begin
            rev_source_sel <= k[1:0];
            rev_digital_in <= k[2];
         end
         u_master.send({k[3], 15'h0400});
         settle();
         e = (k[1:0] == 0) ? k[2] : (k[1:0] == 1) ? k[3] : (k[1:0] == 2) ? k[2] | k[3] : k[2] & k[3];
         check(16'(reverse_r), 16'(e));
      end
      u_master.send(16'h0000);
      settle();
      check(16'(reverse_r), 16'h0001);
      $display("test reverse done");
      summarize();
   end
endmodule
